/* inc/pzg_pkg.sv */
// Purpose: shared constants and types for the port zero gpio block
// Assumes: axi4-lite register access, 32-bit data, 250 MHz clock
// Notes: offsets are byte addresses of aligned words
package pzg_pkg;
  // ==========================================================
  // register map
  localparam logic [3:0] PZG_OFS_DATA = 4'h0; // data latch / pin read
  localparam logic [3:0] PZG_OFS_DIR = 4'h4; // direction
  localparam logic [3:0] PZG_OFS_AIDIS = 4'h8; // analog input disable
  localparam logic [3:0] PZG_OFS_CTRL = 4'hc; // standby / lcd control
  localparam logic [3:0] PZG_OFS_DATA_RMW = 4'h0; // rmw alias base nibble
  localparam logic [4:0] PZG_OFS_RMW_HI = 5'h10; // rmw view of the latch
  // ==========================================================
  // reset values
  localparam logic [7:0] PZG_RST_DATA = 8'h00;
  localparam logic [7:0] PZG_RST_DIR = 8'h00;
  localparam logic [7:0] PZG_RST_AIDIS = 8'h00;
  localparam logic [7:0] PZG_RST_SEGSEL = 8'h00;
  // ==========================================================
  // control register field positions
  localparam int PZG_CTRL_PIN_STATE = 0; // standby pin state bit
  localparam int PZG_CTRL_PORT_IN_CTL = 1; // port input control bit
  localparam int PZG_CTRL_SEGSEL_LSB = 8; // segment select bits [15:8]
  // ==========================================================
  // axi responses
  localparam logic [1:0] PZG_RESP_OKAY = 2'b00;
  localparam logic [1:0] PZG_RESP_SLVERR = 2'b10;
  // ==========================================================
  // pin bundles travel together
  typedef struct packed {
    logic [7:0] outVal; // level driven when enabled
    logic [7:0] outEn; // high while the port drives
  } pzg_pin_drv_t;
  typedef struct packed {
    logic [7:0] periphOut; // shared peripheral output levels
    logic [7:0] periphEn; // shared peripheral output enables
  } pzg_periph_t;
endpackage

/* hdl/pzg_sync.sv */
// Purpose: two-flop synchroniser for the eight pin inputs
// Assumes: one clock domain on the capture side
// Notes: first stage read only by the second stage
`timescale 1ns/10ps
module pzg_sync (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // data
  input wire logic [7:0] asyncIn,
  output logic [7:0] syncOut
);
  import pzg_pkg::*;
  // ==========================================================
  // metastability chain
  logic [7:0] meta_ff; // first stage, not observed elsewhere
  logic [7:0] sync_ff; // second stage, safe to use
  always_ff @(posedge clk) begin
    if (srst) begin
      meta_ff <= 8'h00;
      sync_ff <= 8'h00;
    end else begin
      meta_ff <= asyncIn;
      sync_ff <= meta_ff;
    end
  end
  assign syncOut = sync_ff;
endmodule

/* hdl/pzg_pad_gate.sv */
// Purpose: per-pin drive and input gating with standby isolation
// Assumes: inputs other than periph and irqEn are registered by the caller
// Notes: purely combinational per bit, generated eight times
`timescale 1ns/10ps
module pzg_pad_gate (
  // configuration
  input wire logic [7:0] dirBits,
  input wire logic [7:0] latchBits,
  input wire logic [7:0] segSel,
  input wire logic portInCtl,
  input wire logic isolate,
  input wire logic [7:0] irqEn,
  // peripheral outputs
  input wire pzg_pkg::pzg_periph_t periph,
  // synchronised pin levels
  input wire logic [7:0] pinSync,
  // results
  output pzg_pkg::pzg_pin_drv_t drv,
  output logic [7:0] digIn
);
  import pzg_pkg::*;
  // ==========================================================
  // one slice per pin; bit n serves pin n
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_pin
      // a segment pin is owned by the lcd once the input control is set
      logic lcdOwned;
      assign lcdOwned = segSel[gi] & portInCtl;
      // port drive wins over peripheral; isolation kills both
      assign drv.outEn[gi] = ~isolate & ~lcdOwned &
                             (dirBits[gi] | periph.periphEn[gi]);
      assign drv.outVal[gi] = dirBits[gi] ? latchBits[gi] : periph.periphOut[gi];
      // isolated inputs lock low unless external interrupt is armed
      assign digIn[gi] = (isolate & ~irqEn[gi]) ? 1'b0 : pinSync[gi];
    end
  endgenerate
endmodule

/* hdl/pzg_port0.sv */
// Purpose: eight-bit port zero with analog, lcd and interrupt sharing
// Assumes: axi4-lite master keeps one write and one read in flight
// Notes: read-modify-write reads use the alias offset at 0x10
// Operation
// R1 - direction one makes pin drive latch
// R2 - output pin shows current latch value
// R3 - writes always latch; inputs not driven
// R4 - output pin read returns latch
// R5 - input pin: pin read; rmw: latch
// R6 - peripheral drive visible on ordinary reads
// R7 - software sets disable bit for digital
// R8 - reset clears direction and analog disable
// R9 - standby with pin state isolates pins
// R10 - armed interrupt pins keep input open
// R11 - pin state zero keeps pins unchanged
// R12 - software clears both bits for analog
// R13 - pin level always feeds interrupt circuit; here unarmed pins feed 0 while isolated
// R14 - software sequence for lcd segment use
// R15 - software sequence for gpio on lcd pin
// R16 - software disables other shared outputs
// R17 - data read differs; latch via rmw
// R18 - peripheral input pin reads pin level
// R19 - software disables unused external interrupts
// R20 - bit n controls pin n
// R21 - pins synchronised by two flops
`timescale 1ns/10ps
module pzg_port0 (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // axi4-lite write address
  input wire logic [4:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // axi4-lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read address
  input wire logic [4:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // axi4-lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // pins (three signals each)
  input wire logic [7:0] pinIn,
  output logic [7:0] pinOut,
  output logic [7:0] pinOe,
  // shared peripherals
  input wire pzg_pkg::pzg_periph_t periph,
  input wire logic [7:0] irqEnable,
  input wire logic standbyReq,
  // towards peripherals
  output logic [7:0] irqPinLevel,
  output logic [7:0] digitalIn,
  output logic [7:0] analogEnable,
  output logic [7:0] segmentEnable
);
  import pzg_pkg::*;
  // ==========================================================
  // software registers
  logic [7:0] data_ff; // output latch
  logic [7:0] dir_ff; // direction, 1 = output
  logic [7:0] aidis_ff; // analog input disable
  logic [7:0] segsel_ff; // segment select bits
  logic pinState_ff; // standby pin state bit
  logic portInCtl_ff; // port input control bit
  // ==========================================================
  // bus handshake state
  logic awHeld_ff; // write address captured
  logic wHeld_ff; // write data captured
  logic [4:0] awAddr_ff; // captured write address
  logic [31:0] wData_ff; // captured write data
  logic [3:0] wStrb_ff; // captured strobes
  logic bValid_ff; // write response pending
  logic [1:0] bResp_ff; // write response code
  logic arReady_ff; // read address ready
  logic rValid_ff; // read data pending
  logic [31:0] rData_ff; // read data
  logic [1:0] rResp_ff; // read response code
  // ==========================================================
  // pin side registers
  logic [7:0] pinOut_ff; // registered pin level
  logic [7:0] pinOe_ff; // registered pin enable
  logic [7:0] irqLvl_ff; // level to interrupt circuit
  logic [7:0] digIn_ff; // gated digital input
  logic [7:0] anaEn_ff; // analog path enable
  logic [7:0] segEn_ff; // segment driver enable
  logic isolate_ff; // standby isolation in force
  // ==========================================================
  // combinational helpers
  logic [7:0] pinSync; // synchronised pins
  logic [7:0] gatedIn; // after standby gating
  pzg_pin_drv_t drv; // pad drive from gate
  logic wrFire; // both write halves present
  logic [31:0] ctrlWord; // control register image

  // ==========================================================
  // decoding used by both read and write paths
  function automatic logic addr_known(input logic [4:0] a);
    if (a == {1'b0, PZG_OFS_DATA}) begin
      addr_known = 1'b1;
    end else if (a == {1'b0, PZG_OFS_DIR}) begin
      addr_known = 1'b1;
    end else if (a == {1'b0, PZG_OFS_AIDIS}) begin
      addr_known = 1'b1;
    end else if (a == {1'b0, PZG_OFS_CTRL}) begin
      addr_known = 1'b1;
    end else if (a == PZG_OFS_RMW_HI) begin
      addr_known = 1'b1;
    end else begin
      addr_known = 1'b0;
    end
  endfunction

  // ==========================================================
  // pin capture, then gating
  pzg_sync u_sync (
    .clk(clk),
    .srst(srst),
    .asyncIn(pinIn),
    .syncOut(pinSync) // R21
  );

  pzg_pad_gate u_gate (
    .dirBits(dir_ff),
    .latchBits(data_ff),
    .segSel(segsel_ff),
    .portInCtl(portInCtl_ff),
    .isolate(isolate_ff),
    .irqEn(irqEnable),
    .periph(periph),
    .pinSync(pinSync),
    .drv(drv),
    .digIn(gatedIn)
  );

  assign wrFire = awHeld_ff & wHeld_ff & ~bValid_ff;
  assign ctrlWord = {16'h0000, segsel_ff, 6'h00, portInCtl_ff, pinState_ff};

  // ==========================================================
  // write address / data capture, either order
  always_ff @(posedge clk) begin
    if (srst) begin
      awHeld_ff <= 1'b0;
      awAddr_ff <= 5'h00;
    end else if (s_axi_awvalid && s_axi_awready) begin
      awHeld_ff <= 1'b1;
      awAddr_ff <= s_axi_awaddr;
    end else if (wrFire) begin
      awHeld_ff <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      wHeld_ff <= 1'b0;
      wData_ff <= 32'h0000_0000;
      wStrb_ff <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      wHeld_ff <= 1'b1;
      wData_ff <= s_axi_wdata;
      wStrb_ff <= s_axi_wstrb;
    end else if (wrFire) begin
      wHeld_ff <= 1'b0;
    end
  end

  // ready straight from flops; low while a half is held
  always_ff @(posedge clk) begin
    if (srst) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
    end else begin
      s_axi_awready <= ~awHeld_ff & ~(s_axi_awvalid & s_axi_awready) & ~bValid_ff;
      s_axi_wready <= ~wHeld_ff & ~(s_axi_wvalid & s_axi_wready) & ~bValid_ff;
    end
  end

  // write response after both halves
  always_ff @(posedge clk) begin
    if (srst) begin
      bValid_ff <= 1'b0;
      bResp_ff <= PZG_RESP_OKAY;
    end else if (wrFire) begin
      bValid_ff <= 1'b1;
      bResp_ff <= addr_known(awAddr_ff) ? PZG_RESP_OKAY : PZG_RESP_SLVERR;
    end else if (s_axi_bready) begin
      bValid_ff <= 1'b0;
    end
  end

  // ==========================================================
  // register writes; byte lane 0 carries data, lane 1 also carries the control segment select
  always_ff @(posedge clk) begin
    if (srst) begin
      data_ff <= PZG_RST_DATA;
      dir_ff <= PZG_RST_DIR; // R8
      aidis_ff <= PZG_RST_AIDIS; // R8
      segsel_ff <= PZG_RST_SEGSEL;
      pinState_ff <= 1'b0;
      portInCtl_ff <= 1'b0;
    end else if (wrFire) begin
      // data alias and rmw alias both land in the latch
      if ((awAddr_ff == {1'b0, PZG_OFS_DATA} || awAddr_ff == PZG_OFS_RMW_HI)
          && wStrb_ff[0]) begin
        data_ff <= wData_ff[7:0]; // R3 R20
      end else if (awAddr_ff == {1'b0, PZG_OFS_DIR} && wStrb_ff[0]) begin
        dir_ff <= wData_ff[7:0]; // R20
      end else if (awAddr_ff == {1'b0, PZG_OFS_AIDIS} && wStrb_ff[0]) begin
        aidis_ff <= wData_ff[7:0];
      end else if (awAddr_ff == {1'b0, PZG_OFS_CTRL}) begin
        if (wStrb_ff[0]) begin
          pinState_ff <= wData_ff[PZG_CTRL_PIN_STATE];
          portInCtl_ff <= wData_ff[PZG_CTRL_PORT_IN_CTL];
        end
        if (wStrb_ff[1]) begin
          segsel_ff <= wData_ff[PZG_CTRL_SEGSEL_LSB +: 8];
        end
      end
    end
  end

  // ==========================================================
  // read channel; one read at a time
  always_ff @(posedge clk) begin
    if (srst) begin
      arReady_ff <= 1'b0;
      rValid_ff <= 1'b0;
      rData_ff <= 32'h0000_0000;
      rResp_ff <= PZG_RESP_OKAY;
    end else if (s_axi_arvalid && arReady_ff) begin
      arReady_ff <= 1'b0;
      rValid_ff <= 1'b1;
      rResp_ff <= addr_known(s_axi_araddr) ? PZG_RESP_OKAY : PZG_RESP_SLVERR;
      if (s_axi_araddr == {1'b0, PZG_OFS_DATA}) begin
        // output pins give latch, others the true pin level
        rData_ff <= {24'h000000, (dir_ff & data_ff) | (~dir_ff & pinSync)}; // R4 R5 R6 R18 R17
      end else if (s_axi_araddr == PZG_OFS_RMW_HI) begin
        rData_ff <= {24'h000000, data_ff}; // R5 R17
      end else if (s_axi_araddr == {1'b0, PZG_OFS_DIR}) begin
        rData_ff <= {24'h000000, dir_ff};
      end else if (s_axi_araddr == {1'b0, PZG_OFS_AIDIS}) begin
        rData_ff <= {24'h000000, aidis_ff};
      end else if (s_axi_araddr == {1'b0, PZG_OFS_CTRL}) begin
        rData_ff <= ctrlWord;
      end else begin
        rData_ff <= 32'h0000_0000;
      end
    end else if (rValid_ff) begin
      if (s_axi_rready) begin
        rValid_ff <= 1'b0;
        arReady_ff <= 1'b1;
      end
    end else begin
      arReady_ff <= 1'b1;
    end
  end

  // ==========================================================
  // standby isolation follows request only with pin state set
  always_ff @(posedge clk) begin
    if (srst) begin
      isolate_ff <= 1'b0;
    end else begin
      isolate_ff <= standbyReq & pinState_ff; // R9 R11
    end
  end

  // pin drive and peripheral-side outputs, all registered
  always_ff @(posedge clk) begin
    if (srst) begin
      pinOut_ff <= 8'h00;
      pinOe_ff <= 8'h00;
      irqLvl_ff <= 8'h00;
      digIn_ff <= 8'h00;
      anaEn_ff <= 8'h00;
      segEn_ff <= 8'h00;
    end else begin
      pinOut_ff <= drv.outVal; // R1 R2
      pinOe_ff <= drv.outEn; // R1 R3 R9
      irqLvl_ff <= gatedIn; // R10 R13
      // digital input only where analog use is disabled
      digIn_ff <= gatedIn & aidis_ff;
      anaEn_ff <= ~aidis_ff & ~dir_ff;
      segEn_ff <= segsel_ff & {8{portInCtl_ff}} & ~dir_ff & {8{~isolate_ff}};
    end
  end

  assign pinOut = pinOut_ff;
  assign pinOe = pinOe_ff;
  assign irqPinLevel = irqLvl_ff;
  assign digitalIn = digIn_ff;
  assign analogEnable = anaEn_ff;
  assign segmentEnable = segEn_ff;
  assign s_axi_bvalid = bValid_ff;
  assign s_axi_bresp = bResp_ff;
  assign s_axi_arready = arReady_ff;
  assign s_axi_rvalid = rValid_ff;
  assign s_axi_rdata = rData_ff;
  assign s_axi_rresp = rResp_ff;

  // ==========================================================
  // checks
  sequence s_isoReq;
    standbyReq && pinState_ff;
  endsequence

  a_iso_hiz: assert property (@(posedge clk) disable iff (srst) // R9
    s_isoReq ##1 (standbyReq && pinState_ff) |=> pinOe == 8'h00)
    else $error("pins not isolated in standby");
  a_out_drive: assert property (@(posedge clk) disable iff (srst) // R1
    (!isolate_ff && !portInCtl_ff && $stable(dir_ff) && dir_ff[0]) |=> pinOe[0])
    else $error("output pin not driven");
  a_out_level: assert property (@(posedge clk) disable iff (srst) // R2
    (pinOe[3] && dir_ff[3] && $stable(data_ff) && $stable(dir_ff)) |-> pinOut[3] == data_ff[3])
    else $error("output level differs from latch");
  a_in_nodrive: assert property (@(posedge clk) disable iff (srst) // R3
    (!dir_ff[2] && !periph.periphEn[2]) |=> !pinOe[2])
    else $error("input pin driven");
  a_rd_mux: assert property (@(posedge clk) disable iff (srst) // R4
    (s_axi_arvalid && arReady_ff && s_axi_araddr == 5'h00)
    |=> rData_ff[7:0] == (($past(dir_ff) & $past(data_ff)) | (~$past(dir_ff) & $past(pinSync))))
    else $error("data read mux wrong");
  a_rmw_read: assert property (@(posedge clk) disable iff (srst) // R5
    (s_axi_arvalid && arReady_ff && s_axi_araddr == PZG_OFS_RMW_HI)
    |=> rData_ff[7:0] == $past(data_ff))
    else $error("rmw read not latch");
  a_irq_open: assert property (@(posedge clk) disable iff (srst) // R10
    isolate_ff |=> irqLvl_ff == ($past(pinSync) & $past(irqEnable)))
    else $error("armed interrupt input not kept open");
  a_irq_level: assert property (@(posedge clk) disable iff (srst) // R13
    (!isolate_ff) |=> irqLvl_ff == $past(pinSync))
    else $error("interrupt level lost");
  a_keep_state: assert property (@(posedge clk) disable iff (srst) // R11
    (!pinState_ff) |=> !isolate_ff)
    else $error("isolation without pin state");
  a_reset_dir: assert property (@(posedge clk) // R8
    srst |=> (dir_ff == 8'h00 && aidis_ff == 8'h00))
    else $error("reset did not clear registers");
endmodule

/* testbench/pzg_pin_model.sv */
// Purpose: far-side pin model for the port zero block
// Assumes: one external source per pin; device drive wins
// Notes: an undriven pin flips each cycle instead of keeping a level
`timescale 1ns/10ps
module pzg_pin_model (
  // clock
  input wire logic clk,
  // device side
  input wire logic [7:0] pinOut,
  input wire logic [7:0] pinOe,
  // external source
  input wire logic [7:0] extVal,
  input wire logic [7:0] extEn,
  // resolved wire level
  output logic [7:0] pinIn
);
  logic [7:0] float_ff = 8'h00; // level a released line drifts to
  // ==========================================================
  // wire resolution
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (pinOe[i]) begin
        pinIn[i] = pinOut[i];
      end else if (extEn[i]) begin
        pinIn[i] = extVal[i]; // outside driver
      end else begin
        pinIn[i] = float_ff[i]; // no keeper, so no stale value
      end
    end
  end
  // floating lines change every cycle
  always_ff @(posedge clk) begin
    float_ff <= ~pinIn;
  end
endmodule

/* testbench/tb.sv */
// Purpose: self-checking bench for the port zero block
// Assumes: axi4-lite answer timing as the block states it
// Notes: pin effects are checked after a fixed settle of five edges
`timescale 1ns/10ps
`define CHK(nm, ex, got) begin n_tests++; if ((got) !== (ex)) begin n_fail++; \
  $display("MISMATCH %s expected %h seen %h", nm, ex, got); end end
module tb;
  import pzg_pkg::*;
  // ==========================================================
  // signals
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic [4:0] awAddr = '0, arAddr = '0;
  logic awValid = 1'b0, wValid = 1'b0, bReady = 1'b0, arValid = 1'b0, rReady = 1'b0;
  logic [31:0] wData = '0, rData;
  logic awReady, wReady, bValid, arReady, rValid;
  logic [1:0] bResp, rResp;
  logic [7:0] pinIn, pinOut, pinOe, irqPinLevel, digitalIn, analogEnable, segmentEnable;
  logic [7:0] extVal = 8'hc3, extEn = 8'hff, irqEnable = 8'h00;
  logic standbyReq = 1'b0;
  pzg_periph_t periph = '0; // shared peripheral drive
  int n_fail = 0;
  int n_tests = 0;
  localparam logic [4:0] A_DAT = {1'b0, PZG_OFS_DATA};
  localparam logic [4:0] A_DIR = {1'b0, PZG_OFS_DIR};
  localparam logic [4:0] A_AID = {1'b0, PZG_OFS_AIDIS};
  localparam logic [4:0] A_CTL = {1'b0, PZG_OFS_CTRL};
  localparam logic [4:0] A_RMW = PZG_OFS_RMW_HI;
  // ==========================================================
  // clock, design and far side
  always #2 clk = ~clk;
  pzg_port0 dut (
    .clk(clk), .srst(srst),
    .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid), .s_axi_awready(awReady),
    .s_axi_wdata(wData), .s_axi_wstrb(4'hf), .s_axi_wvalid(wValid), .s_axi_wready(wReady),
    .s_axi_bresp(bResp), .s_axi_bvalid(bValid), .s_axi_bready(bReady),
    .s_axi_araddr(arAddr), .s_axi_arvalid(arValid), .s_axi_arready(arReady),
    .s_axi_rdata(rData), .s_axi_rresp(rResp), .s_axi_rvalid(rValid), .s_axi_rready(rReady),
    .pinIn(pinIn), .pinOut(pinOut), .pinOe(pinOe),
    .periph(periph), .irqEnable(irqEnable), .standbyReq(standbyReq),
    .irqPinLevel(irqPinLevel), .digitalIn(digitalIn),
    .analogEnable(analogEnable), .segmentEnable(segmentEnable)
  );
  pzg_pin_model pins (
    .clk(clk), .pinOut(pinOut), .pinOe(pinOe),
    .extVal(extVal), .extEn(extEn), .pinIn(pinIn)
  );
  // ==========================================================
  // bus tasks: each opens on a fresh edge, so no signal is set twice
  task automatic axiWrite(input logic [4:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    @(posedge clk);
    awAddr <= a;
    wData <= d;
    awValid <= 1'b1;
    wValid <= 1'b1;
    bReady <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (awValid && awReady) awValid <= 1'b0; // address taken
      if (wValid && wReady) wValid <= 1'b0; // data taken
    end while (!(bValid && bReady) && n < 100);
    r = bResp;
    bReady <= 1'b0;
    if (n >= 100) n_fail++;
  endtask
  task automatic axiRead(input logic [4:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    @(posedge clk);
    arAddr <= a;
    arValid <= 1'b1;
    rReady <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (arValid && arReady) arValid <= 1'b0; // address taken
    end while (!(rValid && rReady) && n < 100);
    d = rData;
    r = rResp;
    rReady <= 1'b0;
    if (n >= 100) n_fail++;
  endtask
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    logic [1:0] r;
    axiWrite(a, d, r);
    `CHK("bresp", PZG_RESP_OKAY, r)
  endtask
  task automatic chkRd(input string nm, input logic [4:0] a, input logic [31:0] ex);
    logic [31:0] d;
    logic [1:0] r;
    axiRead(a, d, r);
    `CHK(nm, ex, d)
    `CHK("rresp", PZG_RESP_OKAY, r)
  endtask
  // two sync flops, one register and margin
  task automatic settle;
    repeat (5) @(posedge clk);
  endtask
  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // ==========================================================
  // watchdog: the whole sequence needs well under 2000 cycles
  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    end_of_test();
  end
  // ==========================================================
  // main sequence
  initial begin
    logic [31:0] d;
    logic [1:0] r;
    repeat (6) @(posedge clk);
    srst <= 1'b0;
    repeat (3) @(posedge clk);
    // reset state, pins read as inputs
    chkRd("data", A_DAT, 32'h000000c3);
    chkRd("dir", A_DIR, 32'h0);
    chkRd("aidis", A_AID, 32'h0);
    chkRd("ctrl", A_CTL, 32'h0);
    chkRd("rmw", A_RMW, 32'h0);
    `CHK("anaEn", 8'hff, analogEnable)
    `CHK("digIn", 8'h00, digitalIn)
    `CHK("oe", 8'h00, pinOe)
    // low nibble out, high nibble in, back-to-back writes
    wr(A_DIR, 32'h0000000f);
    wr(A_DAT, 32'h0000005a);
    settle();
    `CHK("oe", 8'h0f, pinOe)
    `CHK("out", 4'ha, pinOut[3:0])
    chkRd("data", A_DAT, 32'h000000ca);
    chkRd("rmw", A_RMW, 32'h0000005a);
    wr(A_DAT, 32'h0000003c);
    settle();
    `CHK("out", 4'hc, pinOut[3:0])
    `CHK("oe", 8'h0f, pinOe)
    wr(A_DIR, 32'h000000ff);
    settle();
    `CHK("out", 8'h3c, pinOut)
    // peripheral owns pins 4 and 5, port released
    wr(A_DIR, 32'h0);
    periph <= '{periphOut: 8'h10, periphEn: 8'h30};
    extEn <= 8'hcf;
    settle();
    `CHK("oe", 8'h30, pinOe)
    chkRd("data", A_DAT, 32'h000000d3);
    chkRd("rmw", A_RMW, 32'h0000003c);
    periph <= '0;
    extEn <= 8'hff;
    extVal <= 8'h96;
    settle();
    chkRd("data", A_DAT, 32'h00000096);
    `CHK("irqLvl", 8'h96, irqPinLevel)
    // analog gating
    wr(A_AID, 32'h000000ff);
    settle();
    `CHK("digIn", 8'h96, digitalIn)
    `CHK("anaEn", 8'h00, analogEnable)
    wr(A_AID, 32'h0000000f);
    wr(A_DIR, 32'h00000010);
    settle();
    `CHK("anaEn", 8'he0, analogEnable)
    `CHK("digIn", 8'h06, digitalIn)
    // standby with isolation, two armed interrupt pins
    wr(A_CTL, 32'h00000001);
    standbyReq <= 1'b1;
    irqEnable <= 8'h84;
    settle();
    `CHK("oe", 8'h00, pinOe)
    `CHK("irqLvl", 8'h84, irqPinLevel)
    `CHK("digInLock", 8'h00, digitalIn & ~irqEnable)
    standbyReq <= 1'b0;
    settle();
    `CHK("oe", 8'h10, pinOe)
    // standby without isolation keeps everything
    wr(A_CTL, 32'h0);
    standbyReq <= 1'b1;
    settle();
    `CHK("oe", 8'h10, pinOe)
    `CHK("out4", 1'b1, pinOut[4])
    `CHK("irqLvl", 8'h96, irqPinLevel)
    standbyReq <= 1'b0;
    irqEnable <= 8'h00;
    // segment select then port use of the shared pins
    wr(A_CTL, 32'h00000300);
    wr(A_CTL, 32'h00000302);
    settle();
    `CHK("segEn", 8'h03, segmentEnable)
    chkRd("ctrl", A_CTL, 32'h00000302);
    wr(A_CTL, 32'h00000002);
    settle();
    `CHK("segEn", 8'h00, segmentEnable)
    `CHK("oe", 8'h10, pinOe)
    // unmapped places are refused and change nothing
    axiRead(5'h14, d, r);
    `CHK("badRd", PZG_RESP_SLVERR, r)
    `CHK("badRdData", 32'h0, d)
    axiWrite(5'h18, 32'h000000ff, r);
    `CHK("badWr", PZG_RESP_SLVERR, r)
    chkRd("dir", A_DIR, 32'h00000010);
    // mid-run reset must clear what software set
    srst <= 1'b1;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    repeat (3) @(posedge clk);
    chkRd("dir", A_DIR, 32'h0);
    chkRd("aidis", A_AID, 32'h0);
    `CHK("anaEn", 8'hff, analogEnable)
    end_of_test();
  end
endmodule
